// file: verilog/spcs_top.sv
// Purpose: Host-facing programming sequencer with ready flags and a simple serial core.
// Assumes: io_wr and io_rd are one-cycle strobes on clk; bit clocks and rx_line are pins.
// Notes:   Sync-mode characters go out unframed; sync-mode reception is not provided.
`timescale 1ns/1ps
`default_nettype none

module spcs_top import spcs_pkg::*; (
  input  wire logic        clk,                // 10 MHz system clock
  input  wire logic        rst_n,              // Async reset, active low
  input  wire logic [15:0] io_addr,            // I/O address
  input  wire logic        io_wr,              // Write strobe
  input  wire logic        io_rd,              // Read strobe
  input  wire logic [7:0]  io_wdata,           // Write data
  output logic      [7:0]  io_rdata,           // Read data, one cycle after io_rd
  input  wire logic        tx_bit_clock,       // Transmit bit clock pin
  input  wire logic        rx_bit_clock,       // Receive bit clock pin
  input  wire logic        rx_line,            // Serial input pin
  output logic             tx_line,            // Serial output
  output logic             tx_holding_free,    // Transmit-ready request
  output logic             rx_char_available   // Receive-ready request
);

  logic        rst_s1;
  logic        rst_sync_n;
  logic [2:0]  pin_s1;
  logic [2:0]  pin_s2;
  logic [1:0]  clk_d;
  logic        tx_tick;
  logic        rx_tick;
  logic        rx_in;

  logic        hit_data;
  logic        hit_ctrl;
  logic        wr_data;
  logic        wr_ctrl;
  logic        rd_data;
  logic        rd_ctrl;

  spcs_phase_e phase;
  logic [7:0]  mode_word;
  logic [7:0]  cmd_word;
  logic [7:0]  sync_char1;
  logic [7:0]  sync_char2;
  logic        init_done;
  logic        is_async;
  logic [6:0]  div;

  logic [7:0]  hold_data;
  logic        hold_full;
  logic        tx_busy;
  logic        tx_load;

  logic        rx_done;
  logic [7:0]  rx_data;
  logic        rx_par_err;
  logic        rx_frm_err;
  logic [7:0]  rx_buf;
  logic        rx_full;
  logic        par_err;
  logic        frm_err;
  logic        overrun;
  logic        err_clr;
  logic [7:0]  status_word;

  // Reset release through two flops; assertion stays asynchronous
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_s1     <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_s1     <= 1'b1;
      rst_sync_n <= rst_s1;
    end
  end

  // Pin synchronisers; only the second stage is looked at
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      pin_s1 <= 3'h7;
      pin_s2 <= 3'h7;
      clk_d  <= 2'h3;
    end else begin
      pin_s1 <= {rx_line, rx_bit_clock, tx_bit_clock};
      pin_s2 <= pin_s1;
      clk_d  <= pin_s2[1:0];
    end
  end

  // Bit clocks come from the timer's square wave; TX moves on falling, RX samples on rising
  assign tx_tick = clk_d[0] & ~pin_s2[0];
  assign rx_tick = ~clk_d[1] & pin_s2[1];
  assign rx_in   = pin_s2[2];

  // Address decode with aliased pairs
  assign hit_data = (io_addr == ADDR_DATA_A) || (io_addr == ADDR_DATA_B);
  assign hit_ctrl = (io_addr == ADDR_CTRL_A) || (io_addr == ADDR_CTRL_B);
  assign wr_data  = io_wr && hit_data;
  assign wr_ctrl  = io_wr && hit_ctrl;
  assign rd_data  = io_rd && hit_data;
  assign rd_ctrl  = io_rd && hit_ctrl;

  // Async is any nonzero factor code
  assign is_async = mode_word[MODE_FACTOR_LSB +: 2] != FACTOR_SYNC;

  // Write phase sequencing of control-port writes
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      phase <= PH_MODE;
    end else if (wr_ctrl) begin
      unique case (phase)
        PH_MODE: begin
          // Factor field decides whether sync slots follow
          phase <= (io_wdata[MODE_FACTOR_LSB +: 2] == FACTOR_SYNC) ? PH_SYNC1 : PH_CMD;
        end
        PH_SYNC1: begin
          phase <= mode_word[MODE_SYNC_ONE] ? PH_CMD : PH_SYNC2;
        end
        PH_SYNC2: begin
          phase <= PH_CMD;
        end
        PH_CMD: begin
          // Reinit bit wins; everything else in that write is ignored
          if (io_wdata[CMD_REINIT]) begin
            phase <= PH_MODE;
          end
        end
      endcase
    end
  end

  // Mode word and sync characters
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      mode_word  <= MODE_RESET_VAL;
      sync_char1 <= 8'h00;
      sync_char2 <= 8'h00;
    end else if (wr_ctrl) begin
      if (phase == PH_MODE) begin
        mode_word <= io_wdata;
      end
      if (phase == PH_SYNC1) begin
        sync_char1 <= io_wdata;
      end
      if (phase == PH_SYNC2) begin
        sync_char2 <= io_wdata;
      end
    end
  end

  // Command word and completion of initialisation
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      cmd_word  <= CMD_RESET_VAL;
      init_done <= 1'b0;
    end else if (wr_ctrl && phase == PH_CMD) begin
      if (io_wdata[CMD_REINIT]) begin
        cmd_word  <= CMD_RESET_VAL;
        init_done <= 1'b0;
      end else begin
        cmd_word  <= io_wdata;
        init_done <= 1'b1;
      end
    end
  end

  // Error clear pulse from a command write
  assign err_clr = wr_ctrl && phase == PH_CMD && !io_wdata[CMD_REINIT] && io_wdata[CMD_ERR_CLR];

  // Bit time per factor; sync mode runs one tick per bit
  always_comb begin
    unique case (mode_word[MODE_FACTOR_LSB +: 2])
      FACTOR_X16: div = DIV_X16;
      FACTOR_X64: div = DIV_X64;
      FACTOR_X1:  div = DIV_X1;
      FACTOR_SYNC: div = DIV_X1;
    endcase
  end

  // Holding register; a write in the same cycle as a hand-off keeps it full
  assign tx_load = hold_full && !tx_busy && init_done && cmd_word[CMD_TX_EN];

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      hold_full <= 1'b0;
      hold_data <= 8'h00;
    end else begin
      if (wr_data && init_done) begin
        hold_data <= io_wdata;
      end
      hold_full <= (wr_data && init_done) || (hold_full && !tx_load);
    end
  end

  spcs_tx u_tx (
    .clk       (clk),
    .rst_n     (rst_sync_n),
    .tick      (tx_tick),
    .load      (tx_load),
    .data      (hold_data),
    .len_code  (mode_word[MODE_LEN_LSB +: 2]),
    .par_en    (mode_word[MODE_PAR_EN]),
    .par_even  (mode_word[MODE_PAR_EVEN]),
    .stop_code (mode_word[MODE_STOP_LSB +: 2]),
    .framed    (is_async),
    .div       (div),
    .brk       (init_done && cmd_word[CMD_BREAK]),
    .busy      (tx_busy),
    .line      (tx_line)
  );

  spcs_rx u_rx (
    .clk      (clk),
    .rst_n    (rst_sync_n),
    .tick     (rx_tick),
    .line     (rx_in),
    .en       (init_done && is_async && cmd_word[CMD_RX_EN]),
    .len_code (mode_word[MODE_LEN_LSB +: 2]),
    .par_en   (mode_word[MODE_PAR_EN]),
    .par_even (mode_word[MODE_PAR_EVEN]),
    .div      (div),
    .done     (rx_done),
    .data     (rx_data),
    .par_err  (rx_par_err),
    .frm_err  (rx_frm_err)
  );

  // Receive buffer; a new character beats a read in the same cycle
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      rx_buf  <= 8'h00;
      rx_full <= 1'b0;
    end else begin
      if (rx_done) begin
        rx_buf <= rx_data;
      end
      rx_full <= rx_done || (rx_full && !rd_data);
    end
  end

  // Sticky errors; setting wins over the clear command
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      par_err <= 1'b0;
      frm_err <= 1'b0;
      overrun <= 1'b0;
    end else begin
      par_err <= (rx_done && rx_par_err) || (par_err && !err_clr);
      frm_err <= (rx_done && rx_frm_err) || (frm_err && !err_clr);
      overrun <= (rx_done && rx_full && !rd_data) || (overrun && !err_clr);
    end
  end

  // Status word assembly
  always_comb begin
    status_word              = 8'h00;
    status_word[ST_TX_FREE]  = init_done && !hold_full;
    status_word[ST_RX_AVAIL] = rx_full;
    status_word[ST_TX_EMPTY] = !hold_full && !tx_busy;
    status_word[ST_PAR_ERR]  = par_err;
    status_word[ST_OVERRUN]  = overrun;
    status_word[ST_FRM_ERR]  = frm_err;
  end

  // Read data registered; unmapped reads return zero
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      io_rdata <= 8'h00;
    end else if (io_rd) begin
      io_rdata <= rd_data ? rx_buf : (rd_ctrl ? status_word : 8'h00);
    end
  end

  // Request outputs lag the status bits by one clock
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      tx_holding_free   <= 1'b0;
      rx_char_available <= 1'b0;
    end else begin
      tx_holding_free   <= status_word[ST_TX_FREE];
      rx_char_available <= status_word[ST_RX_AVAIL];
    end
  end

endmodule : spcs_top

`default_nettype wire

// file: verilog/spcs_pkg.sv
// Purpose: Shared constants and types for the serial port control sequencer.
// Assumes: Host I/O strobes are synchronous to clk; bit clocks arrive on pins.
// Notes:   Field positions follow the mode, command and status word layouts.

package spcs_pkg;

  // Aliased port addresses on the low 16 address bits
  localparam logic [15:0] ADDR_DATA_A = 16'h00d8;
  localparam logic [15:0] ADDR_DATA_B = 16'h00dc;
  localparam logic [15:0] ADDR_CTRL_A = 16'h00da;
  localparam logic [15:0] ADDR_CTRL_B = 16'h00de;

  // Mode word fields
  localparam int          MODE_FACTOR_LSB = 0;
  localparam int          MODE_LEN_LSB    = 2;
  localparam int          MODE_PAR_EN     = 4;
  localparam int          MODE_PAR_EVEN   = 5;
  localparam int          MODE_STOP_LSB   = 6;
  localparam int          MODE_SYNC_ONE   = 7;
  localparam logic [1:0]  FACTOR_SYNC     = 2'h0;
  localparam logic [1:0]  FACTOR_X1       = 2'h1;
  localparam logic [1:0]  FACTOR_X16      = 2'h2;
  localparam logic [1:0]  FACTOR_X64      = 2'h3;
  localparam logic [6:0]  DIV_X1          = 7'h01;
  localparam logic [6:0]  DIV_X16         = 7'h10;
  localparam logic [6:0]  DIV_X64         = 7'h40;
  localparam logic [1:0]  STOP_ONE_HALF   = 2'h2;
  localparam logic [3:0]  LEN_BASE        = 4'h5;

  // Command word fields
  localparam int          CMD_TX_EN       = 0;
  localparam int          CMD_RX_EN       = 2;
  localparam int          CMD_BREAK       = 3;
  localparam int          CMD_ERR_CLR     = 4;
  localparam int          CMD_REINIT      = 6;
  localparam logic [7:0]  CMD_RESET_VAL   = 8'h00;
  localparam logic [7:0]  MODE_RESET_VAL  = 8'h00;

  // Status word fields
  localparam int          ST_TX_FREE      = 0;
  localparam int          ST_RX_AVAIL     = 1;
  localparam int          ST_TX_EMPTY     = 2;
  localparam int          ST_PAR_ERR      = 3;
  localparam int          ST_OVERRUN      = 4;
  localparam int          ST_FRM_ERR      = 5;

  typedef enum logic [1:0] {PH_MODE, PH_SYNC1, PH_SYNC2, PH_CMD} spcs_phase_e;
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} spcs_rx_e;

endpackage : spcs_pkg

// file: verilog/spcs_tx.sv
// Purpose: Serialiser for one character, LSB first, on falling bit clock ticks.
// Assumes: tick is a one-cycle pulse per bit clock falling edge.
// Notes:   Unframed (sync) characters carry no start or stop bits.
`timescale 1ns/1ps
`default_nettype none

module spcs_tx import spcs_pkg::*; (
  input  wire logic       clk,        // System clock
  input  wire logic       rst_n,      // Synchronised reset, active low
  input  wire logic       tick,       // Bit clock falling edge
  input  wire logic       load,       // Take data while idle
  input  wire logic [7:0] data,       // Character
  input  wire logic [1:0] len_code,   // Length 5..8
  input  wire logic       par_en,     // Parity enable
  input  wire logic       par_even,   // Even parity
  input  wire logic [1:0] stop_code,  // Stop bits
  input  wire logic       framed,     // Async framing
  input  wire logic [6:0] div,        // Ticks per bit
  input  wire logic       brk,        // Force line low
  output logic            busy,       // Shifting
  output logic            line        // Serial output
);

  logic [3:0]  nd;
  logic [7:0]  dm;
  logic        par;
  logic [9:0]  body;
  logic [10:0] frame;
  logic [3:0]  nbits_total;
  logic [10:0] shreg;
  logic [3:0]  nbits;
  logic [6:0]  cnt;
  logic [6:0]  last_len;
  logic        step;

  // Frame assembly; bits above the data and parity read as marks
  always_comb begin
    nd          = LEN_BASE + {2'h0, len_code};
    dm          = data & ~(8'hff << nd);
    par         = (^dm) ^ ~par_even;
    body        = {2'h0, dm} | ({9'h1ff, par_en ? par : 1'b1} << nd);
    frame       = framed ? {body, 1'b0} : {1'b1, body};
    nbits_total = nd + {3'h0, par_en} + (framed ? ((stop_code == 2'h1) ? 4'h2 : 4'h3) : 4'h0);
  end

  assign step = tick && busy && (cnt == 7'h00);

  // Bit sequencing; 1.5 stop bits shortens the last bit to half length except at x1
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busy     <= 1'b0;
      shreg    <= '1;
      nbits    <= 4'h0;
      cnt      <= 7'h00;
      last_len <= DIV_X1;
    end else if (load && !busy) begin
      busy     <= 1'b1;
      shreg    <= frame;
      nbits    <= nbits_total;
      cnt      <= 7'h00;
      last_len <= (framed && stop_code == STOP_ONE_HALF && div != DIV_X1) ? (div >> 1) : div;
    end else if (step) begin
      if (nbits == 4'h0) begin
        busy <= 1'b0;
      end else begin
        shreg <= {1'b1, shreg[10:1]};
        nbits <= nbits - 4'h1;
        cnt   <= ((nbits == 4'h1) ? last_len : div) - 7'h01;
      end
    end else if (tick && busy) begin
      cnt <= cnt - 7'h01;
    end
  end

  // Line driver; idle is mark, break holds space
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      line <= 1'b1;
    end else if (brk) begin
      line <= 1'b0;
    end else if (step) begin
      line <= (nbits == 4'h0) ? 1'b1 : shreg[0];
    end else if (!busy) begin
      // Back to mark once break drops while idle
      line <= 1'b1;
    end
  end

endmodule : spcs_tx

`default_nettype wire

// file: verilog/spcs_rx.sv
// Purpose: Asynchronous character receiver sampling on rising bit clock ticks.
// Assumes: line is already synchronised to clk.
// Notes:   Only one stop bit is checked; the rest are treated as idle.
`timescale 1ns/1ps
`default_nettype none

module spcs_rx import spcs_pkg::*; (
  input  wire logic       clk,       // System clock
  input  wire logic       rst_n,     // Synchronised reset, active low
  input  wire logic       tick,      // Bit clock rising edge
  input  wire logic       line,      // Serial input
  input  wire logic       en,        // Receiver on
  input  wire logic [1:0] len_code,  // Length 5..8
  input  wire logic       par_en,    // Parity enable
  input  wire logic       par_even,  // Even parity
  input  wire logic [6:0] div,       // Ticks per bit
  output logic            done,      // Character complete pulse
  output logic [7:0]      data,      // Received character
  output logic            par_err,   // Parity mismatch
  output logic            frm_err    // Missing stop bit
);

  spcs_rx_e   st;
  logic [6:0] cnt;
  logic [2:0] bitn;
  logic [7:0] sh;
  logic       pbit;
  logic [3:0] nd;

  assign nd = LEN_BASE + {2'h0, len_code};

  // Start detection at half a bit except at x1, then one sample per bit time
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st      <= RX_IDLE;
      cnt     <= 7'h00;
      bitn    <= 3'h0;
      sh      <= 8'h00;
      pbit    <= 1'b0;
      done    <= 1'b0;
      data    <= 8'h00;
      par_err <= 1'b0;
      frm_err <= 1'b0;
    end else begin
      done <= 1'b0;
      if (!en) begin
        st <= RX_IDLE;
      end else if (tick) begin
        if (st != RX_IDLE && cnt != 7'h00) begin
          cnt <= cnt - 7'h01;
        end else begin
          unique case (st)
            RX_IDLE: begin
              if (!line) begin
                sh   <= 8'h00;
                bitn <= 3'h0;
                // x1 has no half bit to wait for
                st   <= (div == DIV_X1) ? RX_DATA : RX_START;
                cnt  <= (div == DIV_X1) ? 7'h00 : (div >> 1) - 7'h01;
              end
            end
            RX_START: begin
              // A mark at mid start bit was a glitch
              st  <= line ? RX_IDLE : RX_DATA;
              cnt <= div - 7'h01;
            end
            RX_DATA: begin
              sh[bitn] <= line;
              cnt      <= div - 7'h01;
              bitn     <= bitn + 3'h1;
              if ({1'b0, bitn} == nd - 4'h1) begin
                st <= par_en ? RX_PAR : RX_STOP;
              end
            end
            RX_PAR: begin
              pbit <= line;
              cnt  <= div - 7'h01;
              st   <= RX_STOP;
            end
            RX_STOP: begin
              done    <= 1'b1;
              data    <= sh;
              frm_err <= ~line;
              par_err <= par_en & ((^sh) ^ pbit ^ ~par_even);
              st      <= RX_IDLE;
            end
          endcase
        end
      end
    end
  end

endmodule : spcs_rx

`default_nettype wire

// file: testbench/spcs_host.sv
// Purpose: Host CPU model for I/O cycles, plus the baud timer
// Assumes: Strobes change on falling clk edges
// Notes:   Idle bus lines carry inverted junk, not stale values
`timescale 1ns/1ps
`default_nettype none
module spcs_host import spcs_pkg::*; #(
  parameter int SEARCH_BIT = 7  // Sync search command bit
) (
  input  wire logic        clk,       // Clock
  input  wire logic [7:0]  io_rdata,  // Read data
  output logic      [15:0] io_addr,   // Address
  output logic             io_wr,     // Write strobe
  output logic             io_rd,     // Read strobe
  output logic      [7:0]  io_wdata,  // Write data
  output logic             bit_clk    // Baud square wave
);
  logic [3:0] div;
  // Timer square wave feeds both bit clocks
  assign bit_clk = div[3];  // Timer out
  initial begin
    div      = 4'h0;
    io_addr  = 16'h0000;
    io_wr    = 1'b0;
    io_rd    = 1'b0;
    io_wdata = 8'h00;
  end
  // Runs free, like the real timer
  always @(negedge clk) div <= div + 4'h1;
  // One strobed cycle, then junk so stale values never match
  task automatic cyc(input logic w, input logic [15:0] a, input logic [7:0] d);
    @(negedge clk);
    io_addr  = a;
    io_wdata = d;
    io_wr    = w;
    io_rd    = !w;
    @(negedge clk);
    io_wr    = 1'b0;
    io_rd    = 1'b0;
    io_addr  = ~a;
    io_wdata = ~d;
  endtask : cyc
  // Write; spacing kept for every write, cheap and safe
  task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic cmd);
    if (cmd && d[CMD_RX_EN] && d[SEARCH_BIT]) d[CMD_ERR_CLR] = 1'b1;  // Clear errors
    cyc(1'b1, a, d);
    repeat (16) @(negedge clk);  // Recovery gap
  endtask : wr
  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    cyc(1'b0, a, 8'h00);
    d = io_rdata;
  endtask : rd
  // Poll ready before data or command writes
  task automatic wait_tx(output logic ok);
    logic [7:0] s;
    ok = 1'b0;
    repeat (1500) if (!ok) begin  // Poll
      rd(ADDR_CTRL_A, s);
      ok = s[ST_TX_FREE] === 1'b1;
    end
  endtask : wait_tx
endmodule : spcs_host
`default_nettype wire

// file: testbench/spcs_top_assertions.sv
// Purpose: Port checks for spcs_top
// Assumes: Strobes start after the reset synchroniser
// Notes:   Shadows the write phase from control writes
`timescale 1ns/1ps
`default_nettype none
module spcs_chk import spcs_pkg::*; (
  input wire logic        clk,               // Clock
  input wire logic        rst_n,             // Reset
  input wire logic [15:0] io_addr,           // Address
  input wire logic        io_wr,             // Write
  input wire logic        io_rd,             // Read
  input wire logic [7:0]  io_wdata,          // Wdata
  input wire logic [7:0]  io_rdata,          // Rdata
  input wire logic        tx_holding_free,   // Tx ready
  input wire logic        rx_char_available  // Rx ready
);
  spcs_phase_e ph;
  logic        one, init, ctl, dat, cw;
  assign ctl = io_addr == ADDR_CTRL_A || io_addr == ADDR_CTRL_B;
  assign dat = io_addr == ADDR_DATA_A || io_addr == ADDR_DATA_B;
  assign cw  = io_wr && ctl;
  // Phase shadow; init marks a finished sequence
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ph   <= PH_MODE;
      one  <= 1'b0;
      init <= 1'b0;
    end else if (cw) begin
      case (ph)
        PH_MODE: begin
          ph  <= io_wdata[1:0] == FACTOR_SYNC ? PH_SYNC1 : PH_CMD;
          one <= io_wdata[MODE_SYNC_ONE];
        end
        PH_SYNC1: ph <= one ? PH_CMD : PH_SYNC2;
        PH_SYNC2: ph <= PH_CMD;
        default: begin
          ph   <= io_wdata[CMD_REINIT] ? PH_MODE : PH_CMD;
          init <= !io_wdata[CMD_REINIT];
        end
      endcase
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  AST_IDLE_UNTIL_INIT: assert property (
    !init && !$past(init) |-> !tx_holding_free)
    else $error("tx ready before init");
  AST_INIT_READY: assert property (
    cw && ph == PH_CMD && !init && !io_wdata[CMD_REINIT] |-> ##2 tx_holding_free)
    else $error("no tx ready after init");
  AST_REINIT_DROPS: assert property (
    cw && ph == PH_CMD && io_wdata[CMD_REINIT] |-> ##2 (!tx_holding_free) [*3])
    else $error("tx ready after reinit");
  AST_STATUS_PINS: assert property (
    io_rd && ctl |=> io_rdata[1:0] == {rx_char_available, tx_holding_free} && io_rdata[7:6] == 2'h0)
    else $error("status differs from pins");
  AST_UNMAPPED_ZERO: assert property (
    io_rd && !ctl && !dat |=> io_rdata == 8'h00)
    else $error("unmapped read not zero");
  AST_RDATA_HOLDS: assert property (
    !io_rd |=> $stable(io_rdata))
    else $error("read data moved");
  AST_TX_CLEARS: assert property (
    io_wr && dat && tx_holding_free |-> ##2 !tx_holding_free)
    else $error("tx ready kept after data write");
  AST_RX_CLEARS: assert property (
    io_rd && dat && rx_char_available |-> ##2 !rx_char_available)
    else $error("rx ready kept after read");
endmodule : spcs_chk
bind spcs_top spcs_chk u_chk (.clk, .rst_n, .io_addr, .io_wr, .io_rd, .io_wdata, .io_rdata,
  .tx_holding_free, .rx_char_available);
`default_nettype wire

// file: testbench/tb_top.sv
// Purpose: Self-checking bench for spcs_top
// Assumes: Host model owns the I/O bus
// Notes:   tx_line loops back to rx_line
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import spcs_pkg::*;
  logic        clk = 1'b0;  // Starts low with no time-zero edge
  logic        rst_n, io_wr, io_rd, bclk, tx_line, txf, rxa;
  logic [15:0] io_addr;
  logic [7:0]  io_wdata, io_rdata, s;
  int          mismatches, checks_done;
  // Clock, 100 ns period
  initial begin
    forever #50 clk = ~clk;
  end
  spcs_host u_host (.clk(clk), .io_rdata(io_rdata), .io_addr(io_addr), .io_wr(io_wr),
    .io_rd(io_rd), .io_wdata(io_wdata), .bit_clk(bclk));
  spcs_top DUT (.clk(clk), .rst_n(rst_n), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd),
    .io_wdata(io_wdata), .io_rdata(io_rdata), .tx_bit_clock(bclk), .rx_bit_clock(bclk),
    .rx_line(tx_line), .tx_line(tx_line), .tx_holding_free(txf), .rx_char_available(rxa));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic results;
    $display("checks=%0d mismatches=%0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : results
  // Bounded wait; a frame is about 2.6k cycles
  task automatic wait_rx;
    int n;
    n = 0;
    while (rxa !== 1'b1 && n < 6000) begin
      @(negedge clk);
      n++;
    end
    chk({7'h0, rxa}, 8'h01); // Char
  endtask : wait_rx
  task automatic t_reset;
    chk({5'h0, tx_line, rxa, txf}, 8'h04); // Idle
    u_host.rd(ADDR_CTRL_A, s);
    chk(s & 8'h03, 8'h00); // Flags
  endtask : t_reset
  task automatic t_async;
    u_host.wr(ADDR_CTRL_A, 8'h4e, 1'b0);
    chk({7'h0, txf}, 8'h00); // Mode
    u_host.wr(ADDR_CTRL_B, 8'h05, 1'b1);
    chk({7'h0, txf}, 8'h01); // Cmd
    u_host.rd(ADDR_CTRL_B, s);
    chk(s & 8'h03, 8'h01); // Alias
  endtask : t_async
  // Second char waits in holding while the first shifts
  task automatic t_data;
    logic ok;
    u_host.wait_tx(ok);
    chk({7'h0, ok}, 8'h01); // Ready
    u_host.wr(ADDR_DATA_A, 8'ha5, 1'b0);
    u_host.wait_tx(ok);
    chk({7'h0, ok}, 8'h01); // Ready
    u_host.wr(ADDR_DATA_B, 8'h3c, 1'b0);
    chk({7'h0, txf}, 8'h00); // Full
    wait_rx();
    u_host.rd(ADDR_CTRL_B, s);
    chk(s & 8'h02, 8'h02); // Rx bit
    u_host.rd(ADDR_DATA_A, s);
    chk(s, 8'ha5); // Data
    repeat (2) @(negedge clk);
    chk({7'h0, rxa}, 8'h00); // Cleared
    wait_rx();
    u_host.rd(ADDR_DATA_B, s);
    chk(s, 8'h3c); // Alias
    u_host.rd(16'h00d6, s);
    chk(s, 8'h00); // Unmapped
  endtask : t_data
  // Sync chars carry bit0 set, so a skipped slot shows
  task automatic t_sync;
    logic ok;
    u_host.wait_tx(ok);
    chk({7'h0, ok}, 8'h01); // Ready
    u_host.wr(ADDR_CTRL_A, 8'h45, 1'b1); // Reinit
    chk({7'h0, txf}, 8'h00); // Reinit
    u_host.wr(ADDR_CTRL_A, 8'h0c, 1'b0);
    u_host.wr(ADDR_CTRL_A, 8'h17, 1'b0);
    u_host.wr(ADDR_CTRL_A, 8'h17, 1'b0);
    chk({7'h0, txf}, 8'h00); // Syncs
    u_host.wr(ADDR_CTRL_A, 8'h01, 1'b1);
    chk({7'h0, txf}, 8'h01); // Cmd
    u_host.wait_tx(ok);
    chk({7'h0, ok}, 8'h01); // Ready
    u_host.wr(ADDR_CTRL_B, 8'h40, 1'b1);
    u_host.wr(ADDR_CTRL_B, 8'h8c, 1'b0);
    u_host.wr(ADDR_CTRL_B, 8'h17, 1'b0);
    chk({7'h0, txf}, 8'h00); // One sync
    u_host.wr(ADDR_CTRL_B, 8'h01, 1'b1);
    chk({7'h0, txf}, 8'h01); // Cmd
    u_host.wr(ADDR_CTRL_B, 8'h09, 1'b1); // Break on
    chk({7'h0, tx_line}, 8'h00); // Break
    u_host.wait_tx(ok);
    u_host.wr(ADDR_CTRL_B, 8'h01, 1'b1);
    chk({7'h0, tx_line}, 8'h01); // Mark
  endtask : t_sync
  initial begin
    rst_n       = 1'b0;
    mismatches  = 0;
    checks_done = 0;
    repeat (12) @(negedge clk);
    rst_n = 1'b1;
    repeat (3) @(negedge clk);
    t_reset();
    t_async();
    t_data();
    t_sync();
    results();
  end
  // Watchdog, far above the ~5.3k cycles needed
  initial begin
    repeat (40000) @(posedge clk);
    mismatches++;
    results();
  end
endmodule : tb_top
`default_nettype wire
